/* hw/ccs_params.svh */
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH
// register byte offsets
`define CCS_OFS_OSC_CTRL    12'h000
`define CCS_OFS_OSC_TUNE    12'h004
`define CCS_OFS_SEC_TIMER   12'h008
// oscillator control fields
`define CCS_CTRL_IDLE_BIT   7
`define CCS_CTRL_IRCF_HI    6
`define CCS_CTRL_IRCF_LO    4
`define CCS_CTRL_PRIMARY_STARTUP_DONE_BIT   3
`define CCS_CTRL_INTERNAL_FREQ_STABLE_BIT   2
`define CCS_CTRL_SCS_HI     1
`define CCS_CTRL_SCS_LO     0
// tuning fields
`define CCS_TUNE_LF_BIT     7
`define CCS_TUNE_MULT_BIT   6
`define CCS_TUNE_VAL_HI     4
`define CCS_TUNE_VAL_LO     0
// secondary timer control fields
`define CCS_T1_RUN_BIT      6
`define CCS_T1_OSCEN_BIT    3
// reset values and codes
`define CCS_IRCF_RST        3'h4
`define CCS_SCS_RST         2'h0
`define CCS_IRCF_LF         3'h0
`define CCS_MULT_IRCF       2'h3
`define CCS_FOSC_INT_A      4'h8
`define CCS_FOSC_INT_B      4'h9
`define CCS_DIV_FULL        8'hff
// oscillator input positions
`define CCS_OSC_PRI         0
`define CCS_OSC_SEC         1
`define CCS_OSC_FAST        2
`define CCS_OSC_SLOW        3
// timing
`define CCS_OST_TICKS       11'h400
`define CCS_SW_OLD_TICKS    2'h2
`define CCS_SW_NEW_TICKS    2'h3
`define CCS_CLK_PERIOD_NS   25
`define CCS_INTERNAL_FREQ_STABLE_SETTLE_NS  1000000
`endif

/* hw/ccs_pkg.sv */
package ccs_pkg;
	typedef enum logic [2:0] {
		CCS_SW_RUN   = 3'b001,
		CCS_SW_DRAIN = 3'b010,
		CCS_SW_FILL  = 3'b100
	} ccs_sw_state_t;

	typedef enum logic [2:0] {
		CCS_PM_RUN   = 3'b001,
		CCS_PM_IDLE  = 3'b010,
		CCS_PM_SLEEP = 3'b100
	} ccs_pm_state_t;

	typedef enum logic [1:0] {
		CCS_SRC_PRI = 2'h0,
		CCS_SRC_SEC = 2'h1,
		CCS_SRC_INT = 2'h2
	} ccs_src_t;

	function automatic ccs_src_t ccs_src_of(input logic [1:0] sel);
		if (sel[1])
			return CCS_SRC_INT;
		return sel[0] ? CCS_SRC_SEC : CCS_SRC_PRI;
	endfunction : ccs_src_of
endpackage : ccs_pkg

/* hw/ccs_clk_switch.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccs_params.svh"
module ccs_clk_switch
	import ccs_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	// source ticks and requested source
	input  wire logic [2:0] i_ticks,
	input  var  ccs_src_t   i_src,
	// switched device clock
	output logic            o_clk_en,
	output var  ccs_src_t   o_active,
	output logic            o_settled
);
	ccs_sw_state_t st_q, st_d;
	ccs_src_t      cur_q, cur_d, nxt_q, nxt_d;
	logic [1:0]    cnt_q, cnt_d;
	logic          en_q, en_d;

	always_comb begin
		st_d  = st_q;
		cur_d = cur_q;
		nxt_d = nxt_q;
		cnt_d = cnt_q;
		en_d  = 1'b0;
		unique case (st_q)
			CCS_SW_RUN: begin
				en_d = i_ticks[cur_q];
				if (i_src != cur_q) begin
					st_d  = CCS_SW_DRAIN;
					nxt_d = i_src;
					cnt_d = '0;
					en_d  = 1'b0;
				end
			end
			// output held low while the old source counts out two ticks, no runt pulse
			CCS_SW_DRAIN: if (i_ticks[cur_q]) begin
				if (cnt_q == `CCS_SW_OLD_TICKS - 2'h1) begin
					st_d  = CCS_SW_FILL;
					cnt_d = '0;
				end else
					cnt_d = cnt_q + 2'h1;
			end
			CCS_SW_FILL: begin
				if (i_src != nxt_q) begin
					nxt_d = i_src;
					cnt_d = '0;
				end else if (i_ticks[nxt_q]) begin
					if (cnt_q == `CCS_SW_NEW_TICKS - 2'h1) begin
						st_d  = CCS_SW_RUN;
						cur_d = nxt_q;
						cnt_d = '0;
					end else
						cnt_d = cnt_q + 2'h1;
				end
			end
			default: st_d = CCS_SW_RUN;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q  <= CCS_SW_RUN;
			cur_q <= CCS_SRC_PRI;
			nxt_q <= CCS_SRC_PRI;
			cnt_q <= '0;
			en_q  <= 1'b0;
		end else begin
			st_q  <= st_d;
			cur_q <= cur_d;
			nxt_q <= nxt_d;
			cnt_q <= cnt_d;
			en_q  <= en_d;
		end
	end

	assign o_clk_en  = en_q;
	assign o_active  = cur_q;
	assign o_settled = (st_q == CCS_SW_RUN);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_sw_start;
		st_q == CCS_SW_RUN && i_src != cur_q;
	endsequence

	property p_sw_route;
		st_q == CCS_SW_RUN && i_src == cur_q |=> o_clk_en == $past(i_ticks[cur_q]);
	endproperty
	a_sw_route: assert property (p_sw_route) else $error("switched clock not from source");

	property p_sw_pause;
		s_sw_start |=> !o_clk_en [*5];
	endproperty
	a_sw_pause: assert property (p_sw_pause) else $error("switch pause too short");
endmodule : ccs_clk_switch
`default_nettype wire

/* hw/ccs_top.sv */
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_params.svh"
// Operation
// - select field routes primary, secondary or internal
// - select write switches clock after two old and three new ticks
// - every reset clears select to primary
// - frequency field picks 8 MHz down to 31 kHz
// - frequency change acts on output immediately
// - frequency resets to 1 MHz, idle bit to zero
// - low code uses fast/256 or slow RC
// - slow RC always clocks watchdog
// - startup bit set when timer expired, primary runs
// - stable bit set when fast osc clocks device via internal select
// - secondary active bit shows secondary clock use
// - at most one clock status bit set
// - sleep goes idle or full sleep by bit
// - secondary select ignored while its oscillator off
// - glitch-free switch, two old plus three new
// - startup bit reset follows two-speed config
// - primary mode comes from nonvolatile config field
// - multiplier only at top two codes, internal primary
// - tuning value is signed five bits
module ccs_top
	import ccs_pkg::*;
#(
	parameter int unsigned INTERNAL_FREQ_STABLE_SETTLE_CYC =
		(`CCS_INTERNAL_FREQ_STABLE_SETTLE_NS + `CCS_CLK_PERIOD_NS - 1) / `CCS_CLK_PERIOD_NS
)(
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_sys_rst,
	// apb slave
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [11:0]       i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic [31:0]            o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	// oscillator pins, async
	input  wire logic              i_pri_osc,
	input  wire logic              i_sec_osc,
	input  wire logic              i_fast_osc,
	input  wire logic              i_slow_rc,
	// nonvolatile configuration
	input  wire logic [3:0]        i_primary_osc_config,
	input  wire logic              i_two_speed_startup_config,
	// cpu power requests
	input  wire logic              i_sleep_req,
	input  wire logic              i_wake_req,
	// clock enables and state
	output logic                   o_cpu_clk_en,
	output logic                   o_periph_clk_en,
	output logic                   o_wdt_clk_en,
	output logic                   o_mult_en,
	output logic signed [4:0]      o_tuning_value,
	output logic                   o_idle_mode,
	output logic                   o_sleep_mode
);
	localparam logic [15:0] SETTLE_LAST = 16'(INTERNAL_FREQ_STABLE_SETTLE_CYC - 1);

	////////////////////////////////////////////////////////////////////////
	logic [3:0] osc_raw;
	logic [3:0] tick;
	assign osc_raw = {i_slow_rc, i_fast_osc, i_sec_osc, i_pri_osc};

	for (genvar g = 0; g < 4; g++) begin : g_sync
		logic meta_q, sync_q, prev_q;
		always_ff @(posedge i_clk or posedge i_sys_rst) begin
			if (i_sys_rst) begin
				meta_q <= 1'b0;
				sync_q <= 1'b0;
				prev_q <= 1'b0;
			end else begin
				meta_q <= osc_raw[g];
				sync_q <= meta_q;
				prev_q <= sync_q;
			end
		end
		assign tick[g] = sync_q & ~prev_q;
	end

	////////////////////////////////////////////////////////////////////////
	logic       idle_en_q, idle_en_d;
	logic [2:0] ircf_q, ircf_d;
	logic [1:0] scs_q, scs_d;
	logic       lf_q, lf_d;
	logic       mult_q, mult_d;
	logic [4:0] tun_q, tun_d;
	logic       oscen_q, oscen_d;
	logic       pready_q, pready_d;
	logic       err_q, err_d;
	logic [31:0] rdata_q, rdata_d;

	logic access, hit_ctrl, hit_tune, hit_t1, mapped, wr;
	logic primary_startup_done, internal_freq_stable, secondary_clock_active, pri_is_int, mult_avail;
	logic [31:0] rd;

	assign access   = i_psel & i_penable;
	assign hit_ctrl = (i_paddr == `CCS_OFS_OSC_CTRL);
	assign hit_tune = (i_paddr == `CCS_OFS_OSC_TUNE);
	assign hit_t1   = (i_paddr == `CCS_OFS_SEC_TIMER);
	assign mapped   = hit_ctrl | hit_tune | hit_t1;
	assign wr       = access & pready_q & i_pwrite & ~err_q;

	assign pri_is_int = (i_primary_osc_config == `CCS_FOSC_INT_A)
		| (i_primary_osc_config == `CCS_FOSC_INT_B);
	assign mult_avail = pri_is_int & (ircf_q[2:1] == `CCS_MULT_IRCF);

	always_comb begin
		rd = '0;
		if (hit_ctrl) begin
			rd[`CCS_CTRL_IDLE_BIT] = idle_en_q;
			rd[`CCS_CTRL_IRCF_HI:`CCS_CTRL_IRCF_LO] = ircf_q;
			rd[`CCS_CTRL_PRIMARY_STARTUP_DONE_BIT] = primary_startup_done;
			rd[`CCS_CTRL_INTERNAL_FREQ_STABLE_BIT] = internal_freq_stable;
			rd[`CCS_CTRL_SCS_HI:`CCS_CTRL_SCS_LO] = scs_q;
		end else if (hit_tune) begin
			rd[`CCS_TUNE_LF_BIT]   = lf_q;
			rd[`CCS_TUNE_MULT_BIT] = mult_q & mult_avail;
			rd[`CCS_TUNE_VAL_HI:`CCS_TUNE_VAL_LO] = tun_q;
		end else if (hit_t1) begin
			rd[`CCS_T1_RUN_BIT]   = secondary_clock_active;
			rd[`CCS_T1_OSCEN_BIT] = oscen_q;
		end
	end

	always_comb begin
		idle_en_d = idle_en_q;
		ircf_d    = ircf_q;
		scs_d     = scs_q;
		lf_d      = lf_q;
		mult_d    = mult_q;
		tun_d     = tun_q;
		oscen_d   = oscen_q;
		pready_d  = access & ~pready_q;
		err_d     = access & ~pready_q & ~mapped;
		rdata_d   = rdata_q;
		if (access & ~pready_q & ~i_pwrite)
			rdata_d = rd;
		if (wr & hit_ctrl) begin
			idle_en_d = i_pwdata[`CCS_CTRL_IDLE_BIT];
			ircf_d    = i_pwdata[`CCS_CTRL_IRCF_HI:`CCS_CTRL_IRCF_LO];
			// sec request dropped while its oscillator is off
			if (ccs_src_of(i_pwdata[`CCS_CTRL_SCS_HI:`CCS_CTRL_SCS_LO]) != CCS_SRC_SEC
				|| oscen_q)
				scs_d = i_pwdata[`CCS_CTRL_SCS_HI:`CCS_CTRL_SCS_LO];
		end
		if (wr & hit_tune) begin
			lf_d   = i_pwdata[`CCS_TUNE_LF_BIT];
			mult_d = i_pwdata[`CCS_TUNE_MULT_BIT];
			tun_d  = i_pwdata[`CCS_TUNE_VAL_HI:`CCS_TUNE_VAL_LO];
		end
		if (wr & hit_t1)
			oscen_d = i_pwdata[`CCS_T1_OSCEN_BIT];
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			idle_en_q <= 1'b0;
			ircf_q    <= `CCS_IRCF_RST;
			scs_q     <= `CCS_SCS_RST;
			lf_q      <= 1'b0;
			mult_q    <= 1'b0;
			tun_q     <= '0;
			oscen_q   <= 1'b0;
			pready_q  <= 1'b0;
			err_q     <= 1'b0;
			rdata_q   <= '0;
		end else begin
			idle_en_q <= idle_en_d;
			ircf_q    <= ircf_d;
			scs_q     <= scs_d;
			lf_q      <= lf_d;
			mult_q    <= mult_d;
			tun_q     <= tun_d;
			oscen_q   <= oscen_d;
			pready_q  <= pready_d;
			err_q     <= err_d;
			rdata_q   <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [7:0] ps_q, ps_d;
	logic [7:0] ps_mask;
	logic       int_tick, pri_tick, fast_on;
	logic       dev_en, settled;
	ccs_src_t   active;

	assign fast_on = (ircf_q != `CCS_IRCF_LF) | lf_q;
	// postscaler taps follow the field live, no resync on change
	assign ps_mask = (ircf_q == `CCS_IRCF_LF) ? `CCS_DIV_FULL
		: (`CCS_DIV_FULL >> (4'(ircf_q) + 4'h1));
	assign ps_d = tick[`CCS_OSC_FAST] ? ps_q + 8'h01 : ps_q;

	always_comb begin
		if (ircf_q == `CCS_IRCF_LF && !lf_q)
			int_tick = tick[`CCS_OSC_SLOW];
		else
			int_tick = tick[`CCS_OSC_FAST] & ((ps_q & ps_mask) == ps_mask);
	end
	assign pri_tick = pri_is_int ? int_tick : tick[`CCS_OSC_PRI];

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			ps_q <= '0;
		else
			ps_q <= ps_d;
	end

	ccs_clk_switch u_switch (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_ticks   ({int_tick, tick[`CCS_OSC_SEC], pri_tick}),
		.i_src     (ccs_src_of(scs_q)),
		.o_clk_en  (dev_en),
		.o_active  (active),
		.o_settled (settled)
	);

	////////////////////////////////////////////////////////////////////////
	logic        init_q, init_d;
	logic        ost_done_q, ost_done_d;
	logic [10:0] ost_cnt_q, ost_cnt_d;
	logic        stable_q, stable_d;
	logic [15:0] stab_cnt_q, stab_cnt_d;

	always_comb begin
		init_d     = 1'b0;
		ost_done_d = ost_done_q;
		ost_cnt_d  = ost_cnt_q;
		stable_d   = stable_q;
		stab_cnt_d = stab_cnt_q;
		// strap taken after release, two-speed start begins not ready
		if (init_q)
			ost_done_d = ~i_two_speed_startup_config;
		else if (!ost_done_q && pri_tick) begin
			ost_cnt_d = ost_cnt_q + 11'h001;
			if (ost_cnt_q == `CCS_OST_TICKS - 11'h001)
				ost_done_d = 1'b1;
		end
		if (!fast_on || (wr && hit_tune)) begin
			stable_d   = 1'b0;
			stab_cnt_d = '0;
		end else if (!stable_q) begin
			stab_cnt_d = stab_cnt_q + 16'h0001;
			stable_d   = (stab_cnt_q == SETTLE_LAST);
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			init_q     <= 1'b1;
			ost_done_q <= 1'b0;
			ost_cnt_q  <= '0;
			stable_q   <= 1'b0;
			stab_cnt_q <= '0;
		end else begin
			init_q     <= init_d;
			ost_done_q <= ost_done_d;
			ost_cnt_q  <= ost_cnt_d;
			stable_q   <= stable_d;
			stab_cnt_q <= stab_cnt_d;
		end
	end

	// each flag needs the switch settled on its own source
	assign primary_startup_done  = ost_done_q & settled & (active == CCS_SRC_PRI);
	assign internal_freq_stable  = stable_q & fast_on & settled & (active == CCS_SRC_INT);
	assign secondary_clock_active = settled & (active == CCS_SRC_SEC);

	////////////////////////////////////////////////////////////////////////
	ccs_pm_state_t pm_q, pm_d;
	logic cpu_q, cpu_d, per_q, per_d, wdt_q, mult_en_q;

	always_comb begin
		pm_d = pm_q;
		unique case (pm_q)
			CCS_PM_RUN: if (i_sleep_req)
				pm_d = idle_en_q ? CCS_PM_IDLE : CCS_PM_SLEEP;
			CCS_PM_IDLE, CCS_PM_SLEEP: if (i_wake_req)
				pm_d = CCS_PM_RUN;
			default: pm_d = CCS_PM_RUN;
		endcase
		cpu_d = dev_en & (pm_q == CCS_PM_RUN);
		per_d = dev_en & (pm_q != CCS_PM_SLEEP);
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pm_q      <= CCS_PM_RUN;
			cpu_q     <= 1'b0;
			per_q     <= 1'b0;
			wdt_q     <= 1'b0;
			mult_en_q <= 1'b0;
		end else begin
			pm_q      <= pm_d;
			cpu_q     <= cpu_d;
			per_q     <= per_d;
			wdt_q     <= tick[`CCS_OSC_SLOW];
			mult_en_q <= mult_q & mult_avail;
		end
	end

	assign o_prdata        = rdata_q;
	assign o_pready        = pready_q;
	assign o_pslverr       = err_q;
	assign o_cpu_clk_en    = cpu_q;
	assign o_periph_clk_en = per_q;
	assign o_wdt_clk_en    = wdt_q;
	assign o_mult_en       = mult_en_q;
	assign o_tuning_value  = tun_q;
	assign o_idle_mode     = (pm_q == CCS_PM_IDLE);
	assign o_sleep_mode    = (pm_q == CCS_PM_SLEEP);

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_enter_idle;
		pm_q == CCS_PM_RUN && i_sleep_req && idle_en_q;
	endsequence
	sequence s_enter_sleep;
		pm_q == CCS_PM_RUN && i_sleep_req && !idle_en_q;
	endsequence

	property p_sec_ignored;
		wr && hit_ctrl && !oscen_q
			&& i_pwdata[`CCS_CTRL_SCS_HI:`CCS_CTRL_SCS_LO] == CCS_SRC_SEC |=> $stable(scs_q);
	endproperty
	a_sec_ignored: assert property (p_sec_ignored) else $error("secondary taken while off");

	property p_scs_write;
		wr && hit_ctrl && oscen_q |=> scs_q == $past(i_pwdata[1:0]);
	endproperty
	a_scs_write: assert property (p_scs_write) else $error("select write lost");

	property p_status_onehot;
		$onehot0({primary_startup_done, internal_freq_stable, secondary_clock_active});
	endproperty
	a_status_onehot: assert property (p_status_onehot) else $error("two status bits set");

	property p_idle;
		s_enter_idle |=> pm_q == CCS_PM_IDLE ##1 !o_cpu_clk_en;
	endproperty
	a_idle: assert property (p_idle) else $error("idle not entered");

	property p_sleep;
		s_enter_sleep |=> pm_q == CCS_PM_SLEEP ##1 (!o_periph_clk_en && !o_cpu_clk_en);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered");

	property p_mult;
		o_mult_en |-> $past(ircf_q[2:1]) == 2'b11 && $past(pri_is_int);
	endproperty
	a_mult: assert property (p_mult) else $error("multiplier on outside its modes");

	property p_wdt;
		tick[`CCS_OSC_SLOW] |=> o_wdt_clk_en;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog clock missed");

	property p_low_rc;
		ircf_q == 3'h0 && !lf_q |-> int_tick == tick[`CCS_OSC_SLOW];
	endproperty
	a_low_rc: assert property (p_low_rc) else $error("low code not slow rc");
endmodule : ccs_top
`default_nettype wire

/* bench/ccs_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccs_params.svh"
module ccs_top_test
	import ccs_pkg::*;
;
	logic              i_clk, i_sys_rst, i_psel, i_penable, i_pwrite;
	logic [11:0]       i_paddr;
	logic [31:0]       i_pwdata, o_prdata, r;
	logic              o_pready, o_pslverr, last_err;
	logic              i_pri_osc, i_sec_osc, i_fast_osc, i_slow_rc;
	logic [3:0]        i_primary_osc_config;
	logic              i_two_speed_startup_config, i_sleep_req, i_wake_req;
	logic              o_cpu_clk_en, o_periph_clk_en, o_wdt_clk_en, o_mult_en;
	logic              o_idle_mode, o_sleep_mode;
	logic signed [4:0] o_tuning_value;
	logic [4:0]        t;
	logic [2:0]        f;
	int                errors, checks;
	int unsigned       cyc;

	ccs_top #(.INTERNAL_FREQ_STABLE_SETTLE_CYC(16)) dut (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
		.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_pri_osc(i_pri_osc), .i_sec_osc(i_sec_osc),
		.i_fast_osc(i_fast_osc), .i_slow_rc(i_slow_rc),
		.i_primary_osc_config(i_primary_osc_config),
		.i_two_speed_startup_config(i_two_speed_startup_config),
		.i_sleep_req(i_sleep_req), .i_wake_req(i_wake_req),
		.o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en),
		.o_wdt_clk_en(o_wdt_clk_en), .o_mult_en(o_mult_en),
		.o_tuning_value(o_tuning_value), .o_idle_mode(o_idle_mode),
		.o_sleep_mode(o_sleep_mode)
	);

	always #12.5 i_clk = ~i_clk;

	// sources tied to the bench clock so gaps are exact: 6, 8, 4, 10 cycles
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc % 3 == 0)
			i_pri_osc <= ~i_pri_osc;
		if (cyc % 4 == 0)
			i_sec_osc <= ~i_sec_osc;
		if (cyc % 2 == 0)
			i_fast_osc <= ~i_fast_osc;
		if (cyc % 5 == 0)
			i_slow_rc <= ~i_slow_rc;
	end

	////////////////////////////////////////////////////////////////////////
	task close_out;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task do_reset(input logic [3:0] cfg, input logic two_speed);
		i_sys_rst                  <= 1'b1;
		i_primary_osc_config       <= cfg;
		i_two_speed_startup_config <= two_speed;
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'b0;
	endtask : do_reset

	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		i_psel    <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite  <= wr;
		i_paddr   <= a;
		i_pwdata  <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		@(posedge i_clk);
		while (o_pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge i_clk);
		end
		if (n >= 50)
			errors++;
		r         = o_prdata;
		last_err  = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask : xfer

	task wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, 32'(d));
	endtask : wr

	task rdc(input logic [11:0] a, input logic [7:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(r, 32'(e));
	endtask : rdc

	// third spacing only: the first may straddle a switch or a divider phase
	task gap(input logic w, input int e);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge i_clk);
				n++;
			end while ((w ? o_wdt_clk_en : o_cpu_clk_en) !== 1'b1 && n < 3000);
		end
		chk(32'(n), 32'(e));
	endtask : gap

	task power(input logic idle);
		int nc, np;
		nc = 0;
		np = 0;
		wr(`CCS_OFS_OSC_CTRL, {idle, 7'h40});
		@(posedge i_clk);
		i_sleep_req <= 1'b1;
		@(posedge i_clk);
		i_sleep_req <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk({30'h0, o_idle_mode, o_sleep_mode}, {30'h0, idle, ~idle});
		repeat (60) begin
			@(posedge i_clk);
			nc += int'(o_cpu_clk_en === 1'b1);
			np += int'(o_periph_clk_en === 1'b1);
		end
		chk(32'(nc), 32'h0000_0000);
		chk(32'(np > 0), 32'(idle));
		@(posedge i_clk);
		i_wake_req <= 1'b1;
		@(posedge i_clk);
		i_wake_req <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk({30'h0, o_idle_mode, o_sleep_mode}, 32'h0000_0000);
	endtask : power

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge i_clk);
		errors++;
		close_out;
	end

	initial begin
		{i_clk, i_psel, i_penable, i_pwrite, i_sleep_req, i_wake_req} = '0;
		{i_pri_osc, i_sec_osc, i_fast_osc, i_slow_rc} = '0;
		i_paddr  = 12'h000;
		i_pwdata = 32'h0000_0000;
		i_sys_rst = 1'b1;
		i_primary_osc_config = 4'h2;
		i_two_speed_startup_config = 1'b1;
		errors = 0;
		checks = 0;
		cyc = 0;
		void'($urandom(18));
		do_reset(4'h2, 1'b1);
		rdc(`CCS_OFS_OSC_CTRL, 8'h40);
		rdc(`CCS_OFS_OSC_TUNE, 8'h00);
		rdc(`CCS_OFS_SEC_TIMER, 8'h00);
		rdc(12'h00c, 8'h00);
		chk(32'(last_err), 32'h0000_0001);
		wr(`CCS_OFS_OSC_CTRL, 8'h41);
		rdc(`CCS_OFS_OSC_CTRL, 8'h40);
		// oscillator running before it is selected
		wr(`CCS_OFS_SEC_TIMER, 8'h08);
		wr(`CCS_OFS_OSC_CTRL, 8'h41);
		gap(1'b0, 8);
		rdc(`CCS_OFS_SEC_TIMER, 8'h48);
		wr(`CCS_OFS_OSC_CTRL, 8'h4d);
		rdc(`CCS_OFS_OSC_CTRL, 8'h41);
		for (int k = 0; k < 3; k++) begin
			t = (k == 0) ? 5'h0f : (k == 1) ? 5'h10 : 5'($urandom);
			// multiplier bit set: it must stay off with an external primary
			wr(`CCS_OFS_OSC_TUNE, {3'b010, t});
			@(posedge i_clk);
			chk({27'h0, o_tuning_value}, 32'(t));
			chk(32'(o_tuning_value < 0), 32'(t[4]));
			rdc(`CCS_OFS_OSC_TUNE, {3'b000, t});
			chk(32'(o_mult_en), 32'h0000_0000);
		end
		wr(`CCS_OFS_OSC_CTRL, 8'h72);
		gap(1'b0, 4);
		repeat (30) @(posedge i_clk);
		rdc(`CCS_OFS_OSC_CTRL, 8'h76);
		rdc(`CCS_OFS_SEC_TIMER, 8'h08);
		repeat (5) begin
			f = 3'($urandom_range(7, 1));
			wr(`CCS_OFS_OSC_CTRL, {1'b0, f, 4'b0010});
			gap(1'b0, 4 << (7 - f));
		end
		wr(`CCS_OFS_OSC_TUNE, 8'h80);
		wr(`CCS_OFS_OSC_CTRL, 8'h02);
		gap(1'b0, 1024);
		gap(1'b1, 10);
		wr(`CCS_OFS_OSC_TUNE, 8'h00);
		gap(1'b0, 10);
		gap(1'b1, 10);
		wr(`CCS_OFS_OSC_CTRL, 8'h40);
		gap(1'b0, 6);
		// 1024 primary edges at six cycles each, with margin
		repeat (6500) @(posedge i_clk);
		rdc(`CCS_OFS_OSC_CTRL, 8'h48);
		power(1'b1);
		power(1'b0);
		do_reset(4'h9, 1'b0);
		xfer(1'b0, `CCS_OFS_OSC_CTRL, 32'h0000_0000);
		chk(r & 32'h0000_00fb, 32'h0000_0048);
		wr(`CCS_OFS_OSC_TUNE, 8'h40);
		wr(`CCS_OFS_OSC_CTRL, 8'h60);
		rdc(`CCS_OFS_OSC_TUNE, 8'h40);
		chk(32'(o_mult_en), 32'h0000_0001);
		wr(`CCS_OFS_OSC_CTRL, 8'h50);
		repeat (2) @(posedge i_clk);
		chk(32'(o_mult_en), 32'h0000_0000);
		close_out;
	end
endmodule : ccs_top_test
`default_nettype wire
